// ==== verilog/clock_path_pkg.sv ====
package clock_path_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] FIRST_FUNC_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] PLL_CFG_ADDR = 8'h02;
    localparam logic [ADDR_W-1:0] FOURTH_FUNC_ADDR = 8'h03;
    localparam logic [ADDR_W-1:0] LOCK_STATUS_ADDR = 8'h1b;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h1c;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 8'h1d;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 8'h1e;

    // Field positions.
    localparam int OSC_CAL_BIT = 24;
    localparam int CONV_CAL_BIT = 24;
    localparam int SYNC_CAL_BIT = 8;
    localparam int DIV_SEL_LSB = 20;
    localparam int DIV_SEL_W = 2;
    localparam int DOUBLER_BIT = 19;
    localparam int PLL_EN_BIT = 18;
    localparam int DIV_PATH_BIT = 17;
    localparam int EDGE_BIT = 16;
    localparam int FB_N_LSB = 8;
    localparam int FB_N_W = 8;
    localparam int LOCK_DET_EN_BIT = 2;
    localparam int LOCK_BIT = 24;

    // Reset values.
    localparam logic [DATA_W-1:0] FIRST_FUNC_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PLL_CFG_RESET = 32'h0000_0a00;
    localparam logic [DATA_W-1:0] FOURTH_FUNC_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

    // Reference divider settings.
    localparam logic [DIV_SEL_W-1:0] DIV_BYPASS = 2'h0;
    localparam logic [DIV_SEL_W-1:0] DIV_BY_2 = 2'h1;
    localparam logic [DIV_SEL_W-1:0] DIV_BY_4 = 2'h2;
    localparam logic [DIV_SEL_W-1:0] DIV_BY_8 = 2'h3;
    localparam int DIV_CNT_W = 3;

    // Interrupt status layout.
    localparam int IRQ_W = 4;
    localparam int IRQ_OSC_DONE = 0;
    localparam int IRQ_CONV_DONE = 1;
    localparam int IRQ_LOCK_GAINED = 2;
    localparam int IRQ_LOCK_LOST = 3;

    // Calibration timing, in clock cycles or sync clock periods.
    localparam int CAL_CNT_W = 20;
    localparam int OSC_CAL_CYCLES = 1024;
    localparam int CONV_CAL_PERIODS = 469632;
    localparam int SYNC_CAL_PERIODS = 16;
    localparam int SYNC_CNT_W = 5;

    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_SYNC} cal_state_t;
endpackage

// ==== verilog/ref_path_if.sv ====
interface ref_path_if;
    logic ce;
    logic div_path;
    logic doubler;
    logic edge_falling;
    logic [1:0] div_sel;
    logic [7:0] feedback_n;
    logic pll_ref;
    logic [8:0] feedback_mult;

    modport ctrl (
        output ce,
        output div_path,
        output doubler,
        output edge_falling,
        output div_sel,
        output feedback_n,
        input pll_ref,
        input feedback_mult
    );

    modport path (
        input ce,
        input div_path,
        input doubler,
        input edge_falling,
        input div_sel,
        input feedback_n,
        output pll_ref,
        output feedback_mult
    );
endinterface

// ==== verilog/ref_router.sv ====
module ref_router
    import clock_path_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ref_level,
    ref_path_if.path cfg
);
    logic ref_d;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic next_ref;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_d <= 1'b0;
        end else if (cfg.ce) begin
            ref_d <= ref_level;
        end
    end

    // The divider advances on rising edges of the inverted reference.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (cfg.ce && ref_d && !ref_level) begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    always_comb begin
        next_ref = ref_level;
        if (cfg.div_path) begin
            case (cfg.div_sel)
                DIV_BYPASS: next_ref = !ref_level;
                DIV_BY_2: next_ref = div_cnt[0];
                DIV_BY_4: next_ref = div_cnt[1];
                DIV_BY_8: next_ref = div_cnt[2];
                default: next_ref = !ref_level;
            endcase
        end else if (cfg.doubler) begin
            // One pulse per reference edge gives twice the reference rate.
            next_ref = ref_level ^ ref_d;
        end else if (cfg.edge_falling) begin
            next_ref = !ref_level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg.pll_ref <= 1'b0;
            cfg.feedback_mult <= 9'h000;
        end else if (cfg.ce) begin
            cfg.pll_ref <= next_ref;
            cfg.feedback_mult <= {cfg.feedback_n, 1'b0};
        end
    end
endmodule

// ==== verilog/clock_path_ctrl.sv ====
module clock_path_ctrl
    import clock_path_pkg::*;
#(
    parameter int CONV_CAL_LEN = CONV_CAL_PERIODS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [clock_path_pkg::ADDR_W-1:0] addr,
    input wire logic [clock_path_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [clock_path_pkg::DATA_W-1:0] rdata,
    input wire logic ref_clk_pin,
    input wire logic pll_lock_pin,
    input wire logic sync_input_clock,
    output logic pll_ref_clk,
    output logic system_sample_clock_from_pll,
    output logic [8:0] feedback_mult,
    output logic osc_cal_active,
    output logic conv_cal_active,
    output logic irq
);
    import clock_path_pkg::*;

    localparam logic [CAL_CNT_W-1:0] OSC_CAL_LAST = CAL_CNT_W'(OSC_CAL_CYCLES - 1);
    localparam logic [CAL_CNT_W-1:0] CONV_CAL_LAST = CAL_CNT_W'(CONV_CAL_LEN - 1);
    localparam logic [SYNC_CNT_W-1:0] SYNC_CAL_LAST = SYNC_CNT_W'(SYNC_CAL_PERIODS - 1);

    logic [DATA_W-1:0] first_function_register;
    logic [DATA_W-1:0] pll_config_register;
    logic [DATA_W-1:0] fourth_function_register;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] next_irq_status;

    logic [2:0] ref_sync;
    logic [1:0] lock_sync;
    logic [2:0] sync_clk_sync;
    logic sync_rise;

    logic lock_shown;
    logic lock_prev;
    logic osc_req_prev;
    logic conv_req_prev;
    logic osc_start;
    logic conv_start;
    logic osc_done;
    logic conv_done;
    logic [CAL_CNT_W-1:0] osc_cnt;
    logic [CAL_CNT_W-1:0] conv_cnt;
    logic [SYNC_CNT_W-1:0] sync_cnt;
    cal_state_t conv_state;

    ref_path_if path_bus();

    function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = READ_IDLE;
        case (a)
            FIRST_FUNC_ADDR: v = first_function_register;
            PLL_CFG_ADDR: v = pll_config_register;
            FOURTH_FUNC_ADDR: v = fourth_function_register;
            LOCK_STATUS_ADDR: v[LOCK_BIT] = lock_shown;
            IRQ_STATUS_ADDR: v[IRQ_W-1:0] = irq_status;
            IRQ_ENABLE_ADDR: v[IRQ_W-1:0] = irq_enable;
            default: v = READ_IDLE;
        endcase
        return v;
    endfunction

    // Pin inputs cross in through two flip-flops; edge logic reads only the later stages.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_sync <= 3'h0;
            lock_sync <= 2'h0;
            sync_clk_sync <= 3'h0;
        end else if (ce) begin
            ref_sync <= {ref_sync[1:0], ref_clk_pin};
            lock_sync <= {lock_sync[0], pll_lock_pin};
            sync_clk_sync <= {sync_clk_sync[1:0], sync_input_clock};
        end
    end

    assign sync_rise = sync_clk_sync[1] && !sync_clk_sync[2];

    // Register writes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_function_register <= FIRST_FUNC_RESET;
            pll_config_register <= PLL_CFG_RESET;
            fourth_function_register <= FOURTH_FUNC_RESET;
            irq_enable <= '0;
        end else if (ce && wr) begin
            case (addr)
                FIRST_FUNC_ADDR: first_function_register <= wdata;
                PLL_CFG_ADDR: pll_config_register <= wdata;
                FOURTH_FUNC_ADDR: fourth_function_register <= wdata;
                IRQ_ENABLE_ADDR: irq_enable <= wdata[IRQ_W-1:0];
                default: irq_enable <= irq_enable;
            endcase
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= READ_IDLE;
        end else if (ce) begin
            rdata <= rd ? read_mux(addr) : READ_IDLE;
        end
    end

    assign path_bus.ce = ce;
    assign path_bus.div_path = pll_config_register[DIV_PATH_BIT];
    assign path_bus.doubler = pll_config_register[DOUBLER_BIT];
    assign path_bus.edge_falling = pll_config_register[EDGE_BIT];
    assign path_bus.div_sel = pll_config_register[DIV_SEL_LSB +: DIV_SEL_W];
    assign path_bus.feedback_n = pll_config_register[FB_N_LSB +: FB_N_W];

    ref_router router (
        .clk(clk),
        .rst(rst),
        .ref_level(ref_sync[1]),
        .cfg(path_bus.path)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_ref_clk <= 1'b0;
            feedback_mult <= 9'h000;
            system_sample_clock_from_pll <= 1'b0;
        end else if (ce) begin
            pll_ref_clk <= path_bus.pll_ref;
            feedback_mult <= path_bus.feedback_mult;
            system_sample_clock_from_pll <= pll_config_register[PLL_EN_BIT];
        end
    end

    // Lock is shown only while the PLL is in use and the detector is enabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_shown <= 1'b0;
            lock_prev <= 1'b0;
        end else if (ce) begin
            lock_shown <= lock_sync[1] && pll_config_register[PLL_EN_BIT]
                && pll_config_register[LOCK_DET_EN_BIT];
            lock_prev <= lock_shown;
        end
    end

    // A request that stays set is ignored; only its rising edge starts a run.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_req_prev <= 1'b0;
            conv_req_prev <= 1'b0;
        end else if (ce) begin
            osc_req_prev <= first_function_register[OSC_CAL_BIT];
            conv_req_prev <= fourth_function_register[CONV_CAL_BIT];
        end
    end

    assign osc_start = first_function_register[OSC_CAL_BIT] && !osc_req_prev;
    assign conv_start = fourth_function_register[CONV_CAL_BIT] && !conv_req_prev;

    // Oscillator calibration; a new edge during a run restarts it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cal_active <= 1'b0;
            osc_cnt <= '0;
        end else if (ce) begin
            if (osc_start) begin
                osc_cal_active <= 1'b1;
                osc_cnt <= '0;
            end else if (osc_cal_active) begin
                osc_cnt <= osc_cnt + 20'h00001;
                if (osc_cnt == OSC_CAL_LAST) begin
                    osc_cal_active <= 1'b0;
                end
            end
        end
    end

    assign osc_done = ce && osc_cal_active && !osc_start && (osc_cnt == OSC_CAL_LAST);

    // Converter calibration: fixed sample periods, then sync periods when enabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_state <= CAL_IDLE;
            conv_cnt <= '0;
            sync_cnt <= '0;
        end else if (ce) begin
            case (conv_state)
                CAL_IDLE: begin
                    if (conv_start) begin
                        conv_state <= CAL_RUN;
                        conv_cnt <= '0;
                    end
                end
                CAL_RUN: begin
                    conv_cnt <= conv_cnt + 20'h00001;
                    if (conv_cnt == CONV_CAL_LAST) begin
                        sync_cnt <= '0;
                        if (fourth_function_register[SYNC_CAL_BIT]) begin
                            conv_state <= CAL_SYNC;
                        end else begin
                            conv_state <= CAL_IDLE;
                        end
                    end
                end
                CAL_SYNC: begin
                    if (sync_rise) begin
                        sync_cnt <= sync_cnt + 5'h01;
                        if (sync_cnt == SYNC_CAL_LAST) begin
                            conv_state <= CAL_IDLE;
                        end
                    end
                end
                default: conv_state <= CAL_IDLE;
            endcase
        end
    end

    assign conv_done = ce && (((conv_state == CAL_RUN) && (conv_cnt == CONV_CAL_LAST)
        && !fourth_function_register[SYNC_CAL_BIT])
        || ((conv_state == CAL_SYNC) && sync_rise && (sync_cnt == SYNC_CAL_LAST)));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_cal_active <= 1'b0;
        end else if (ce) begin
            conv_cal_active <= (conv_state == CAL_IDLE) ? conv_start : !conv_done;
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle.
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_OSC_DONE] = osc_done;
        irq_events[IRQ_CONV_DONE] = conv_done;
        irq_events[IRQ_LOCK_GAINED] = ce && lock_shown && !lock_prev;
        irq_events[IRQ_LOCK_LOST] = ce && !lock_shown && lock_prev;
        irq_clear = (ce && wr && addr == IRQ_CLEAR_ADDR) ? wdata[IRQ_W-1:0] : '0;
        next_irq_status = (irq_status & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_enable);
        end
    end
endmodule

// ==== bench/clock_path_monitor.sv ====
module clock_path_monitor
    import clock_path_pkg::*;
#(
    parameter int CONV_CAL_LEN = CONV_CAL_PERIODS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [clock_path_pkg::ADDR_W-1:0] addr,
    input wire logic [clock_path_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [clock_path_pkg::DATA_W-1:0] rdata,
    input wire logic system_sample_clock_from_pll,
    input wire logic [8:0] feedback_mult,
    input wire logic osc_cal_active,
    input wire logic conv_cal_active,
    input wire logic irq
);
    // Shadow copies of the writable registers, since the ports alone do not show them.
    logic [DATA_W-1:0] r0, r2, r3, ren;
    int osc_run, conv_run;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r0 <= FIRST_FUNC_RESET;
            r2 <= PLL_CFG_RESET;
            r3 <= FOURTH_FUNC_RESET;
            ren <= '0;
        end else if (ce && wr) begin
            if (addr == FIRST_FUNC_ADDR) r0 <= wdata;
            if (addr == PLL_CFG_ADDR) r2 <= wdata;
            if (addr == FOURTH_FUNC_ADDR) r3 <= wdata;
            if (addr == IRQ_ENABLE_ADDR) ren <= wdata;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_run <= 0;
            conv_run <= 0;
        end else if (ce) begin
            osc_run <= osc_cal_active ? osc_run + 1 : 0;
            conv_run <= conv_cal_active ? conv_run + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence osc_req;
        ce && wr && addr == FIRST_FUNC_ADDR && wdata[OSC_CAL_BIT] && !r0[OSC_CAL_BIT];
    endsequence
    sequence conv_req;
        ce && wr && addr == FOURTH_FUNC_ADDR && wdata[CONV_CAL_BIT] && !r3[CONV_CAL_BIT]
            && !conv_cal_active;
    endsequence
    sequence cfg_settled;
        $stable(r2)[*3];
    endsequence
    chk_mult_twice: assert property (cfg_settled |-> feedback_mult == {r2[15:8], 1'b0})
        else $error("Feedback multiplier does not match twice N.");
    chk_clock_source: assert property (cfg_settled |-> system_sample_clock_from_pll == r2[PLL_EN_BIT])
        else $error("System clock source does not follow the enable bit.");
    chk_lock_hidden: assert property (cfg_settled ##0 (rd && addr == LOCK_STATUS_ADDR
        && !r2[LOCK_DET_EN_BIT]) |=> !rdata[LOCK_BIT])
        else $error("Lock shown while lock detect is off.");
    // The request edge is seen one cycle after the write lands, so activity shows two edges on.
    chk_osc_start: assert property (osc_req |-> ##2 osc_cal_active)
        else $error("Oscillator calibration did not start.");
    chk_osc_length: assert property ($fell(osc_cal_active) |-> osc_run == OSC_CAL_CYCLES)
        else $error("Oscillator calibration length wrong.");
    chk_conv_start: assert property (conv_req |-> ##2 conv_cal_active)
        else $error("Converter calibration did not start.");
    chk_conv_length: assert property ($fell(conv_cal_active) && !r3[SYNC_CAL_BIT]
        |-> conv_run == CONV_CAL_LEN)
        else $error("Converter calibration length wrong.");
    chk_conv_sync: assert property ($fell(conv_cal_active) && r3[SYNC_CAL_BIT]
        |-> conv_run >= CONV_CAL_LEN + SYNC_CAL_PERIODS)
        else $error("Sync extension of calibration too short.");
    chk_irq_conv: assert property ($fell(conv_cal_active) && ren[IRQ_CONV_DONE] |-> ##[0:2] irq)
        else $error("Calibration done interrupt missing.");
endmodule

bind clock_path_ctrl clock_path_monitor #(.CONV_CAL_LEN(CONV_CAL_LEN)) mon (.clk(clk), .rst(rst),
    .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .feedback_mult(feedback_mult),
    .system_sample_clock_from_pll(system_sample_clock_from_pll), .osc_cal_active(osc_cal_active),
    .conv_cal_active(conv_cal_active), .irq(irq));

// ==== bench/ref_clock_path_and_calibration_tb.sv ====
module ref_clock_path_and_calibration_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import clock_path_pkg::*;
    localparam int CAL_LEN = 20;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, ref_run = 1'b0;
    logic ref_clk_pin = 1'b1, pll_lock_pin = 1'b0, sync_input_clock = 1'b0, pe;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, d;
    logic pll_ref_clk, system_sample_clock_from_pll, osc_cal_active, conv_cal_active, irq;
    logic [8:0] feedback_mult;
    logic [7:0] nv;
    int n_errors = 0, tests_run = 0, seed = 92094, cyc = 0, n;
    logic [31:0] cfg [8] = '{32'h0, 32'h1_0000, 32'h2_0000, 32'h12_0000, 32'h2b_0000,
        32'h32_0000, 32'h8_0000, 32'hb_0000};
    int rises [8] = '{16, 16, 16, 8, 4, 2, 32, 16};
    logic [1:0] lvl [8] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};

    clock_path_ctrl #(.CONV_CAL_LEN(CAL_LEN)) dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ref_clk_pin(ref_clk_pin),
        .pll_lock_pin(pll_lock_pin), .sync_input_clock(sync_input_clock),
        .pll_ref_clk(pll_ref_clk), .system_sample_clock_from_pll(system_sample_clock_from_pll),
        .feedback_mult(feedback_mult), .osc_cal_active(osc_cal_active),
        .conv_cal_active(conv_cal_active), .irq(irq));

    always #50 clk = !clk;

    // Reference period is eight clocks so every divided output fits a 128-cycle window whole.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ref_clk_pin <= !ref_run || cyc[2];
        sync_input_clock <= (cyc % 6) < 3;
        if (cyc == 10000) begin
            n_errors++;
            end_of_test;
        end
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic count_rises(output int c);
        logic prev;
        c = 0;
        prev = pll_ref_clk;
        repeat (128) begin
            @(posedge clk);
            #1;
            if (pll_ref_clk && !prev) c++;
            prev = pll_ref_clk;
        end
    endtask

    task automatic active_len(input logic conv, output int c);
        c = 0;
        // Activity rises one edge after the request is taken, so skip that edge first.
        @(posedge clk);
        #1;
        while ((conv ? conv_cal_active : osc_cal_active) === 1'b1 && c < 4000) begin
            c++;
            @(posedge clk);
            #1;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(FIRST_FUNC_ADDR, d);
        check_val(d, FIRST_FUNC_RESET);
        rd_reg(PLL_CFG_ADDR, d);
        check_val(d, PLL_CFG_RESET);
        check_val(system_sample_clock_from_pll, 1'b0);
        rd_reg(FOURTH_FUNC_ADDR, d);
        check_val(d, FOURTH_FUNC_RESET);
        for (int i = 0; i < 8; i++) begin
            nv = (i == 0) ? 8'h0a : (i == 1) ? 8'hff : 8'(10 + {$random(seed)} % 246);
            pe = 1'($random(seed));
            wr_reg(PLL_CFG_ADDR, {13'h0, pe, 2'h0, nv, 8'h00});
            repeat (3) @(posedge clk);
            #1;
            check_val(feedback_mult, {nv, 1'b0});
            check_val(system_sample_clock_from_pll, pe);
        end
        for (int i = 0; i < 8; i++) begin
            wr_reg(PLL_CFG_ADDR, cfg[i] | 32'h4_0a00);
            rd_reg(PLL_CFG_ADDR, d);
            check_val(d, cfg[i] | 32'h4_0a00);
            ref_run <= 1'b1;
            repeat (24) @(posedge clk);
            count_rises(n);
            check_val(n, rises[i]);
            ref_run <= 1'b0;
            repeat (12) @(posedge clk);
            #1;
            if (lvl[i] != 2'h2) check_val(pll_ref_clk, lvl[i][0]);
        end
        pll_lock_pin <= 1'b1;
        wr_reg(PLL_CFG_ADDR, 32'h0004_0a04);
        repeat (8) @(posedge clk);
        rd_reg(LOCK_STATUS_ADDR, d);
        check_val(d, 32'h0100_0000);
        check_val(irq, 1'b0);
        wr_reg(IRQ_ENABLE_ADDR, 32'h4);
        repeat (3) @(posedge clk);
        #1 check_val(irq, 1'b1);
        wr_reg(PLL_CFG_ADDR, 32'h0004_0a00);
        repeat (8) @(posedge clk);
        rd_reg(LOCK_STATUS_ADDR, d);
        check_val(d, 32'h0);
        rd_reg(IRQ_STATUS_ADDR, d);
        check_val(d, 32'hc);
        wr_reg(IRQ_CLEAR_ADDR, 32'hf);
        rd_reg(IRQ_STATUS_ADDR, d);
        check_val(d, 32'h0);
        rd_reg(IRQ_CLEAR_ADDR, d);
        check_val(d, 32'h0);
        rd_reg(8'h55, d);
        check_val(d, 32'h0);
        check_val(irq, 1'b0);
        wr_reg(IRQ_ENABLE_ADDR, 32'h3);
        for (int i = 0; i < 2; i++) begin
            wr_reg(FIRST_FUNC_ADDR, 32'h0100_0000);
            active_len(1'b0, n);
            check_val(n, OSC_CAL_CYCLES);
            repeat (10) @(posedge clk);
            #1 check_val(osc_cal_active, 1'b0);
            check_val(irq, 1'b1);
            wr_reg(IRQ_CLEAR_ADDR, 32'h1);
            wr_reg(FIRST_FUNC_ADDR, 32'h0);
        end
        wr_reg(FOURTH_FUNC_ADDR, 32'h0100_0000);
        wr_reg(FOURTH_FUNC_ADDR, 32'h0);
        active_len(1'b1, n);
        check_val(n, CAL_LEN - 2);
        rd_reg(IRQ_STATUS_ADDR, d);
        check_val(d, 32'h2);
        check_val(irq, 1'b1);
        wr_reg(IRQ_CLEAR_ADDR, 32'h2);
        wr_reg(FOURTH_FUNC_ADDR, 32'h0100_0100);
        wr_reg(FOURTH_FUNC_ADDR, 32'h0000_0100);
        wr_reg(FOURTH_FUNC_ADDR, 32'h0100_0100);
        wr_reg(FOURTH_FUNC_ADDR, 32'h0000_0100);
        active_len(1'b1, n);
        check_val(n + 6 >= CAL_LEN + 88 && n + 6 <= CAL_LEN + 100, 1'b1);
        // Freeze a running calibration; a write made while frozen must not land.
        wr_reg(FIRST_FUNC_ADDR, 32'h0100_0000);
        repeat (100) @(posedge clk);
        ce <= 1'b0;
        wr_reg(PLL_CFG_ADDR, 32'h0000_1400);
        repeat (48) @(posedge clk);
        #1 check_val(osc_cal_active, 1'b1);
        ce <= 1'b1;
        active_len(1'b0, n);
        check_val(n, OSC_CAL_CYCLES - 100);
        rd_reg(PLL_CFG_ADDR, d);
        check_val(d, 32'h0004_0a00);
        check_val(feedback_mult, 9'h014);
        end_of_test;
    end
endmodule
